// file: include/angle_enc_pkg.sv
package angle_enc_pkg;
    // data widths
    localparam int ANGLE_W = 14;
    localparam int CFG_W = 8;
    localparam int NV_COUNT = 5;
    localparam int IMG_W = NV_COUNT * CFG_W;
    localparam int QUAD_W = 11;
    localparam int PCNT_W = 12;
    localparam int RED_W = 5;

    // register map
    localparam logic [ANGLE_W-1:0] ADDR_ZPOS_HIGH = 14'h0016;
    localparam logic [ANGLE_W-1:0] ADDR_ZPOS_LOW = 14'h0017;
    localparam logic [ANGLE_W-1:0] ADDR_CFG1 = 14'h0018;
    localparam logic [ANGLE_W-1:0] ADDR_CFG2 = 14'h0019;
    localparam logic [ANGLE_W-1:0] ADDR_RED = 14'h001A;
    localparam logic [ANGLE_W-1:0] ADDR_MAG = 14'h3FFD;
    localparam logic [ANGLE_W-1:0] ADDR_RAW = 14'h3FFE;
    localparam logic [ANGLE_W-1:0] ADDR_COMP = 14'h3FFF;

    // shadow register slots
    localparam int IDX_ZPOS_HIGH = 0;
    localparam int IDX_ZPOS_LOW = 1;
    localparam int IDX_CFG1 = 2;
    localparam int IDX_CFG2 = 3;
    localparam int IDX_RED = 4;

    // reset values
    localparam logic [CFG_W-1:0] NV_RESET_ZERO = 8'h00;
    localparam logic [CFG_W-1:0] CFG1_RESET = 8'h01;

    // field positions
    localparam int ZPL_MSB = 5;
    localparam int ZPL_HIGH_EN = 6;
    localparam int ZPL_LOW_EN = 7;
    localparam int C1_INDEX_WIDTH_SEL = 0;
    localparam int C1_NOISE = 1;
    localparam int C1_DIR = 2;
    localparam int C1_PIN_SEL = 3;
    localparam int C1_COMP_DIS = 4;
    localparam int C1_DATA_SEL = 6;
    localparam int C1_PWM_ON = 7;
    localparam int C2_PP_LSB = 0;
    localparam int C2_PP_W = 3;
    localparam int C2_HYS_LSB = 3;
    localparam int C2_HYS_W = 2;
    localparam int C2_RES = 5;

    // quadrature and commutation
    localparam logic [QUAD_W-1:0] QMAX_11 = 11'h7FF;
    localparam logic [QUAD_W-1:0] QMAX_10 = 11'h3FF;
    localparam logic [C2_PP_W-1:0] PP_CODE_TOP = 3'h7;
    localparam logic [16:0] SECTORS = 17'h00006;

    // pwm frame
    localparam logic [PCNT_W-1:0] PWM_INIT_LEN = 12'h00C;
    localparam logic [PCNT_W-1:0] PWM_ERR_LEN = 12'h004;
    localparam logic [PCNT_W-1:0] PWM_DATA_LEN = 12'hFFF;
    localparam logic [PCNT_W-1:0] PWM_TAIL_LEN = 12'h008;
    localparam int PWM_FRAME_LEN = 4119;
    localparam int PWM_PERIOD_NS = 444;
    localparam int CLK_MHZ = 20;
    localparam int PWM_DIV_RAW = (PWM_PERIOD_NS * CLK_MHZ) / 1000;
    localparam int PWM_DIV = (PWM_DIV_RAW < 1) ? 1 : PWM_DIV_RAW;
    localparam int DIV_W = 4;
    localparam logic [DIV_W-1:0] PWM_DIV_LAST = DIV_W'(PWM_DIV - 1);

    typedef enum logic [1:0] {PH_INIT, PH_ERRI, PH_DATA, PH_TAIL} pwm_phase_t;
endpackage : angle_enc_pkg

// file: verilog/angle_output_encoders.sv
`timescale 1ns/1ps
module angle_output_encoders (
    // clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // measurement front end
    input wire logic [angle_enc_pkg::ANGLE_W-1:0] magnitude_field_i,
    input wire logic [angle_enc_pkg::ANGLE_W-1:0] raw_angle_field_i,
    input wire logic [angle_enc_pkg::ANGLE_W-1:0] corrected_angle_field_i,
    input wire logic field_too_high_i,
    input wire logic field_too_low_i,
    input wire logic cordic_overflow_flag_i,
    input wire logic offset_loop_done_i,
    input wire logic startup_done_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [angle_enc_pkg::ANGLE_W-1:0] reg_addr_i,
    input wire logic [angle_enc_pkg::ANGLE_W-1:0] reg_wdata_i,
    output logic [angle_enc_pkg::ANGLE_W-1:0] reg_rdata_o,
    // fuse array
    input wire logic otp_burned_i,
    input wire logic [angle_enc_pkg::IMG_W-1:0] otp_image_i,
    input wire logic otp_program_i,
    output logic otp_burn_o,
    output logic [angle_enc_pkg::IMG_W-1:0] otp_burn_data_o,
    // position pins
    output logic quad_a_o,
    output logic quad_b_o,
    output logic quad_index_o,
    output logic comm_u_o,
    output logic comm_v_o,
    output logic comm_w_o,
    output logic noise_setting_o
);
    import angle_enc_pkg::*;

    function automatic logic [CFG_W-1:0] nv_reset(input int idx);
        nv_reset = (idx == IDX_CFG1) ? CFG1_RESET : NV_RESET_ZERO;
    endfunction : nv_reset

    function automatic logic [C2_HYS_W-1:0] hyst_steps(
        input logic res10, input logic [C2_HYS_W-1:0] code);
        if (!res10)
            hyst_steps = 2'h3 - code;
        else
            hyst_steps = 2'h2 - code;
    endfunction : hyst_steps

    function automatic logic [C2_PP_W-1:0] pole_pairs(
        input logic [C2_PP_W-1:0] code);
        pole_pairs = (code == PP_CODE_TOP) ? PP_CODE_TOP : code + 3'h1;
    endfunction : pole_pairs

    function automatic logic [2:0] uvw_pattern(input logic [2:0] sector);
        unique case (sector)
            3'h0: uvw_pattern = 3'h4;
            3'h1: uvw_pattern = 3'h6;
            3'h2: uvw_pattern = 3'h2;
            3'h3: uvw_pattern = 3'h3;
            3'h4: uvw_pattern = 3'h1;
            default: uvw_pattern = 3'h5;
        endcase
    endfunction : uvw_pattern

    // configuration shadow registers and fuse handling
    logic [CFG_W-1:0] cfg_reg [NV_COUNT];
    logic [CFG_W-1:0] cfg_next [NV_COUNT];
    logic load_pending_reg, load_pending_next;
    logic otp_burn_reg, otp_burn_next;
    logic [IMG_W-1:0] burn_data_reg, burn_data_next;
    logic [IMG_W-1:0] image_fixed;
    logic [ANGLE_W-1:0] nv_off;
    logic nv_hit;

    always_comb begin
        image_fixed = otp_image_i;
        // repair bit addressed by the burned pointer field
        image_fixed[otp_image_i[IDX_RED*CFG_W +: RED_W]] = 1'b1;
        nv_off = reg_addr_i - ADDR_ZPOS_HIGH;
        nv_hit = (reg_addr_i >= ADDR_ZPOS_HIGH) && (reg_addr_i <= ADDR_RED);
        load_pending_next = load_pending_reg;
        otp_burn_next = otp_burn_reg;
        burn_data_next = burn_data_reg;
        for (int i = 0; i < NV_COUNT; i++) begin
            cfg_next[i] = cfg_reg[i];
        end
        if (ce_i) begin
            if (load_pending_reg) begin
                load_pending_next = 1'b0;
                if (otp_burned_i) begin
                    for (int i = 0; i < NV_COUNT; i++) begin
                        cfg_next[i] =
                            image_fixed[i*CFG_W +: CFG_W];
                    end
                end
            end else if (reg_wr_i && nv_hit) begin
                cfg_next[nv_off[2:0]] = reg_wdata_i[CFG_W-1:0];
            end
            // a burned array never gets a second burn pulse
            otp_burn_next = otp_program_i && !otp_burned_i
                && !otp_burn_reg;
            for (int i = 0; i < NV_COUNT; i++) begin
                burn_data_next[i*CFG_W +: CFG_W] = cfg_reg[i];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < NV_COUNT; i++) begin
                cfg_reg[i] <= nv_reset(i);
            end
            load_pending_reg <= 1'b1;
            otp_burn_reg <= 1'b0;
            burn_data_reg <= '0;
        end else begin
            for (int i = 0; i < NV_COUNT; i++) begin
                cfg_reg[i] <= cfg_next[i];
            end
            load_pending_reg <= load_pending_next;
            otp_burn_reg <= otp_burn_next;
            burn_data_reg <= burn_data_next;
        end
    end

    // field decode
    logic [ANGLE_W-1:0] zero_pos, angle_used, pos_rel, pos;
    logic index_width_sel, dir_inv, pin_sel, comp_dis, data_sel, pwm_on, res10;
    logic [C2_HYS_W-1:0] hys_code;
    logic [C2_PP_W-1:0] pp_code, ppc;
    logic hard_fault, mag_fault, diag_err;

    always_comb begin
        zero_pos = {cfg_reg[IDX_ZPOS_HIGH],
            cfg_reg[IDX_ZPOS_LOW][ZPL_MSB:0]};
        index_width_sel = cfg_reg[IDX_CFG1][C1_INDEX_WIDTH_SEL];
        dir_inv = cfg_reg[IDX_CFG1][C1_DIR];
        pin_sel = cfg_reg[IDX_CFG1][C1_PIN_SEL];
        comp_dis = cfg_reg[IDX_CFG1][C1_COMP_DIS];
        data_sel = cfg_reg[IDX_CFG1][C1_DATA_SEL];
        pwm_on = cfg_reg[IDX_CFG1][C1_PWM_ON];
        pp_code = cfg_reg[IDX_CFG2][C2_PP_LSB +: C2_PP_W];
        hys_code = cfg_reg[IDX_CFG2][C2_HYS_LSB +: C2_HYS_W];
        res10 = cfg_reg[IDX_CFG2][C2_RES];
        ppc = pole_pairs(pp_code);
        angle_used = comp_dis ? raw_angle_field_i
            : corrected_angle_field_i;
        pos_rel = angle_used - zero_pos;
        pos = dir_inv ? ({ANGLE_W{1'b0}} - pos_rel) : pos_rel;
        hard_fault = !offset_loop_done_i || cordic_overflow_flag_i;
        mag_fault = cfg_reg[IDX_ZPOS_LOW][ZPL_HIGH_EN]
            && cfg_reg[IDX_ZPOS_LOW][ZPL_LOW_EN]
            && (field_too_high_i || field_too_low_i);
        diag_err = hard_fault || mag_fault;
    end

    // quadrature counter with hysteresis
    logic [QUAD_W-1:0] qcnt_reg, qcnt_next, q_target, q_diff, q_mag, q_hyst;
    logic [QUAD_W-1:0] q_max;
    logic chase_reg, chase_next, q_move, q_neg, q_a, q_b, q_idx;

    always_comb begin
        q_target = res10 ? {1'b0, pos[ANGLE_W-1:4]}
            : pos[ANGLE_W-1:3];
        q_diff = q_target - qcnt_reg;
        if (res10) begin
            q_diff = {q_diff[QUAD_W-2], q_diff[QUAD_W-2:0]};
        end
        q_neg = q_diff[QUAD_W-1];
        q_mag = q_neg ? ({QUAD_W{1'b0}} - q_diff) : q_diff;
        q_hyst = {{(QUAD_W-C2_HYS_W){1'b0}},
            hyst_steps(res10, hys_code)};
        // once past the hysteresis band, chase the target all the way
        q_move = (q_diff != '0) && (chase_reg || (q_mag > q_hyst));
        qcnt_next = qcnt_reg;
        chase_next = chase_reg;
        if (ce_i) begin
            if (q_move) begin
                qcnt_next = q_neg ? qcnt_reg - 11'h001 : qcnt_reg + 11'h001;
            end
            if (res10) begin
                qcnt_next[QUAD_W-1] = 1'b0;
            end
            chase_next = q_move && (q_mag > 11'h001);
        end
        q_a = qcnt_reg[1] ^ qcnt_reg[0];
        q_b = qcnt_reg[1];
        q_max = res10 ? QMAX_10 : QMAX_11;
        if (index_width_sel) begin
            q_idx = (qcnt_reg == '0);
        end else begin
            q_idx = (qcnt_reg == '0) || (qcnt_reg == 11'h001)
                || (qcnt_reg == q_max);
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            qcnt_reg <= '0;
            chase_reg <= 1'b0;
        end else begin
            qcnt_reg <= qcnt_next;
            chase_reg <= chase_next;
        end
    end

    // commutation sector from the full-resolution angle
    logic [16:0] elec_full, sect_full;
    logic [2:0] uvw_raw;

    always_comb begin
        elec_full = 17'(pos) * 17'(ppc);
        sect_full = 17'(elec_full[ANGLE_W-1:0]) * SECTORS;
        uvw_raw = uvw_pattern(sect_full[16:14]);
    end

    // pwm frame generator
    pwm_phase_t phase_reg, phase_next;
    logic [PCNT_W-1:0] pcnt_reg, pcnt_next;
    logic [PCNT_W-1:0] frame_data_reg, frame_data_next;
    logic [DIV_W-1:0] div_reg, div_next;
    logic tick, pwm_level;

    always_comb begin
        tick = (div_reg == PWM_DIV_LAST);
        div_next = div_reg;
        pcnt_next = pcnt_reg;
        phase_next = phase_reg;
        frame_data_next = frame_data_reg;
        if (ce_i) begin
            div_next = tick ? '0 : div_reg + 4'h1;
            if (tick) begin
                pcnt_next = pcnt_reg + 12'h001;
                unique case (phase_reg)
                    PH_INIT: if (pcnt_reg == PWM_INIT_LEN - 12'h001) begin
                        phase_next = PH_ERRI;
                        pcnt_next = '0;
                    end
                    PH_ERRI: if (pcnt_reg == PWM_ERR_LEN - 12'h001) begin
                        phase_next = PH_DATA;
                        pcnt_next = '0;
                    end
                    PH_DATA: if (pcnt_reg == PWM_DATA_LEN - 12'h001) begin
                        phase_next = PH_TAIL;
                        pcnt_next = '0;
                    end
                    PH_TAIL: if (pcnt_reg == PWM_TAIL_LEN - 12'h001) begin
                        phase_next = PH_INIT;
                        pcnt_next = '0;
                        // angle is sampled once per frame so data never tears
                        frame_data_next = pos[ANGLE_W-1:2];
                    end
                endcase
            end
        end
        unique case (phase_reg)
            PH_INIT: pwm_level = 1'b1;
            PH_ERRI: pwm_level = !diag_err;
            PH_DATA: pwm_level = !diag_err
                && (pcnt_reg < frame_data_reg);
            PH_TAIL: pwm_level = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_reg <= PH_INIT;
            pcnt_reg <= '0;
            frame_data_reg <= '0;
            div_reg <= '0;
        end else begin
            phase_reg <= phase_next;
            pcnt_reg <= pcnt_next;
            frame_data_reg <= frame_data_next;
            div_reg <= div_next;
        end
    end

    // pin drivers and register read-back
    logic [2:0] abi_reg, abi_next, uvw_reg, uvw_next;
    logic [ANGLE_W-1:0] rdata_reg, rdata_next;

    always_comb begin
        abi_next = abi_reg;
        uvw_next = uvw_reg;
        rdata_next = rdata_reg;
        if (ce_i) begin
            if (!startup_done_i) begin
                abi_next = 3'h7;
                uvw_next = 3'h0;
            end else begin
                abi_next = diag_err ? 3'h7
                    : {q_a, q_b, q_idx};
                uvw_next = diag_err ? 3'h0 : uvw_raw;
                if (pwm_on && !pin_sel) begin
                    uvw_next[0] = pwm_level;
                end
                if (pwm_on && pin_sel) begin
                    abi_next[0] = pwm_level;
                end
            end
            if (reg_rd_i) begin
                if (nv_hit) begin
                    rdata_next = {6'h00, cfg_reg[nv_off[2:0]]};
                end else if (reg_addr_i == ADDR_MAG) begin
                    rdata_next = magnitude_field_i;
                end else if (reg_addr_i == ADDR_RAW) begin
                    rdata_next = raw_angle_field_i;
                end else if (reg_addr_i == ADDR_COMP) begin
                    rdata_next = data_sel ? raw_angle_field_i
                        : corrected_angle_field_i;
                end else begin
                    rdata_next = '0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            abi_reg <= 3'h7;
            uvw_reg <= 3'h0;
            rdata_reg <= '0;
        end else begin
            abi_reg <= abi_next;
            uvw_reg <= uvw_next;
            rdata_reg <= rdata_next;
        end
    end

    assign quad_a_o = abi_reg[2];
    assign quad_b_o = abi_reg[1];
    assign quad_index_o = abi_reg[0];
    assign comm_u_o = uvw_reg[2];
    assign comm_v_o = uvw_reg[1];
    assign comm_w_o = uvw_reg[0];
    assign reg_rdata_o = rdata_reg;
    assign otp_burn_o = otp_burn_reg;
    assign otp_burn_data_o = burn_data_reg;
    assign noise_setting_o = cfg_reg[IDX_CFG1][C1_NOISE];

    // helper: pwm clock periods elapsed in the current frame
    logic [12:0] fticks_reg;
    logic frame_end;
    assign frame_end = ce_i && tick && (phase_reg == PH_TAIL)
        && (pcnt_reg == PWM_TAIL_LEN - 12'h001);
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fticks_reg <= '0;
        end else if (frame_end) begin
            fticks_reg <= '0;
        end else if (ce_i && tick) begin
            fticks_reg <= fticks_reg + 13'h0001;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    property p_startup_quad;
        ce_i && !startup_done_i |=> quad_a_o && quad_b_o && quad_index_o;
    endproperty
    a_startup_quad: assert property (p_startup_quad)
        else $error("quadrature not high during start-up");

    property p_startup_comm;
        ce_i && !startup_done_i |=> !comm_u_o && !comm_v_o && !comm_w_o;
    endproperty
    a_startup_comm: assert property (p_startup_comm)
        else $error("commutation not low during start-up");

    property p_fault_safe;
        ce_i && startup_done_i && hard_fault && !pwm_on
            |=> abi_reg == 3'h7 && uvw_reg == 3'h0;
    endproperty
    a_fault_safe: assert property (p_fault_safe)
        else $error("pins not in safe state on fault");

    property p_frame_len;
        frame_end |-> fticks_reg == 13'(PWM_FRAME_LEN - 1);
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("pwm frame length wrong");

    property p_init_high;
        phase_reg == PH_INIT |-> pwm_level;
    endproperty
    a_init_high: assert property (p_init_high)
        else $error("pwm init section not high");

    property p_err_low;
        phase_reg == PH_ERRI && diag_err |-> !pwm_level;
    endproperty
    a_err_low: assert property (p_err_low)
        else $error("error section not low on error");

    property p_data_off;
        phase_reg == PH_DATA && hard_fault |-> !pwm_level;
    endproperty
    a_data_off: assert property (p_data_off)
        else $error("pwm data not low on fault");

    property p_write_back;
        ce_i && reg_wr_i && reg_addr_i == ADDR_CFG2 && !load_pending_reg
            |=> cfg_reg[IDX_CFG2] == $past(reg_wdata_i[CFG_W-1:0]);
    endproperty
    a_write_back: assert property (p_write_back)
        else $error("soft write not stored");

    property p_burn_once;
        ce_i && otp_burned_i |=> !otp_burn_o;
    endproperty
    a_burn_once: assert property (p_burn_once)
        else $error("burn pulse on burned array");

    property p_read_comp;
        ce_i && reg_rd_i && reg_addr_i == ADDR_COMP && !data_sel
            |=> reg_rdata_o == $past(corrected_angle_field_i);
    endproperty
    a_read_comp: assert property (p_read_comp)
        else $error("top address read wrong source");

    property p_index_narrow;
        index_width_sel && qcnt_reg == 11'h001 |-> !q_idx;
    endproperty
    a_index_narrow: assert property (p_index_narrow)
        else $error("one-step index too wide");
endmodule : angle_output_encoders

// file: sim/quad_host_model.sv
`timescale 1ns/1ps
module quad_host_model (
    // clock and control
    input wire logic clk_sys_i,
    input wire logic clear_i,
    // sensor pins
    input wire logic quad_a_i,
    input wire logic quad_b_i,
    input wire logic quad_index_i,
    input wire logic comm_u_i,
    // decoded counts
    output int step_count_o,
    output int index_count_o,
    output int u_rise_count_o
);
    logic a_reg = 1'b1;
    logic b_reg = 1'b1;
    logic i_reg = 1'b1;
    logic u_reg = 1'b0;
    always_ff @(posedge clk_sys_i) begin
        a_reg <= quad_a_i;
        b_reg <= quad_b_i;
        i_reg <= quad_index_i;
        u_reg <= comm_u_i;
        if (clear_i) begin
            step_count_o <= 0;
            index_count_o <= 0;
            u_rise_count_o <= 0;
        end else begin
            // a leading b counts up, b leading a counts down
            if (quad_a_i != a_reg || quad_b_i != b_reg) begin
                step_count_o <= step_count_o + ((quad_a_i ^ b_reg) ? 1 : -1);
            end
            if (quad_index_i && !i_reg) begin
                index_count_o <= index_count_o + 1;
            end
            if (comm_u_i && !u_reg) begin
                u_rise_count_o <= u_rise_count_o + 1;
            end
        end
    end
endmodule : quad_host_model

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
    import angle_enc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic startup_done = 1'b0, loop_done = 1'b1, too_high = 1'b0;
    logic too_low = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, clear = 1'b1;
    logic [ANGLE_W-1:0] addr = '0, wdata = '0, angle = 14'h2000;
    logic [ANGLE_W-1:0] cordic_magnitude = 14'h0ABC, raw = 14'h1234, rdata;
    logic qa, qb, qi, cu, cv, cw, burn, noise, burned = 1'b0, prog = 1'b0;
    logic [IMG_W-1:0] image = '0, burn_data;
    int steps, idx, urise, n, miscompares = 0, cmp_count = 0, cycles = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    angle_output_encoders dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .ce_i(1'b1), .magnitude_field_i(cordic_magnitude), .raw_angle_field_i(raw),
        .corrected_angle_field_i(angle), .field_too_high_i(too_high),
        .field_too_low_i(too_low), .cordic_overflow_flag_i(1'b0),
        .offset_loop_done_i(loop_done), .startup_done_i(startup_done),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .otp_burned_i(burned),
        .otp_image_i(image), .otp_program_i(prog), .otp_burn_o(burn),
        .otp_burn_data_o(burn_data), .quad_a_o(qa), .quad_b_o(qb),
        .quad_index_o(qi), .comm_u_o(cu), .comm_v_o(cv), .comm_w_o(cw),
        .noise_setting_o(noise));
    quad_host_model host (.clk_sys_i(clk_sys_i), .clear_i(clear),
        .quad_a_i(qa), .quad_b_i(qb), .quad_index_i(qi), .comm_u_i(cu),
        .step_count_o(steps), .index_count_o(idx), .u_rise_count_o(urise));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [13:0] a, input logic [13:0] d);
        @(negedge clk_sys_i);
        reg_wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk_sys_i);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [13:0] a, input logic [13:0] e);
        @(negedge clk_sys_i);
        reg_rd = 1'b1;
        addr = a;
        @(negedge clk_sys_i);
        reg_rd = 1'b0;
        chk({18'h0, rdata}, {18'h0, e});
    endtask : rd
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 95000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        repeat (2) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        chk({26'h0, qa, qb, qi, cu, cv, cw}, 32'h38);
        startup_done = 1'b1;
        rd(ADDR_ZPOS_HIGH, 14'h0000);
        rd(ADDR_ZPOS_LOW, 14'h0000);
        rd(ADDR_CFG1, 14'h0001);
        rd(ADDR_CFG2, 14'h0000);
        rd(ADDR_RED, 14'h0000);
        wr(ADDR_MAG, 14'h0055);
        rd(ADDR_MAG, cordic_magnitude);
        rd(ADDR_COMP, angle);
        wr(ADDR_CFG1, 14'h0041);
        rd(ADDR_COMP, raw);
        rd(ADDR_CFG1, 14'h0041);
        // error frame on the w pin: only the init periods stay high
        loop_done = 1'b0;
        wr(ADDR_CFG1, 14'h0081);
        // skip the partial frame already running when pwm was enabled
        while (cw !== 1'b1) @(negedge clk_sys_i);
        while (cw !== 1'b0) @(negedge clk_sys_i);
        @(posedge cw);
        n = 0;
        @(negedge clk_sys_i);
        while (cw === 1'b1) begin
            n++;
            @(negedge clk_sys_i);
        end
        chk(n, 12 * PWM_DIV);
        chk({27'h0, qa, qb, qi, cu, cv}, 32'h1C);
        // index pin takes the frame, low past its init periods on a fault
        wr(ADDR_CFG1, 14'h0089);
        repeat (2) @(negedge clk_sys_i);
        chk({26'h0, qa, qb, qi, cu, cv, cw}, 32'h30);
        loop_done = 1'b1;
        // one full turn per configuration, hysteresis code giving zero
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_CFG2, 14'(k >= 4 ? 48 + k : 24 + k));
            wr(ADDR_CFG1, k[0] ? 14'h0005 : 14'h0001);
            repeat (1100) @(negedge clk_sys_i);
            clear = 1'b0;
            repeat (4096) begin
                @(negedge clk_sys_i);
                angle = angle + 14'h0004;
            end
            repeat (8) @(negedge clk_sys_i);
            n = (k >= 4 ? 1024 : 2048) * (k[0] ? -1 : 1);
            chk(steps, n);
            chk(idx, 1);
            chk(urise, (k == 7) ? 7 : k + 1);
            clear = 1'b1;
        end
        too_high = 1'b1;
        wr(ADDR_ZPOS_LOW, 14'h0040);
        repeat (3) @(negedge clk_sys_i);
        chk({31'h0, cu | cv | cw}, 32'h1);
        wr(ADDR_ZPOS_LOW, 14'h00C0);
        repeat (3) @(negedge clk_sys_i);
        chk({26'h0, qa, qb, qi, cu, cv, cw}, 32'h38);
        // burn request carries the shadow image
        wr(ADDR_ZPOS_HIGH, 14'h00A5);
        @(negedge clk_sys_i);
        prog = 1'b1;
        @(negedge clk_sys_i);
        prog = 1'b0;
        chk({31'h0, burn}, 32'h1);
        chk(burn_data[31:0], 32'h3705C0A5);
        // unburned array: soft writes are gone after reset
        arst_n_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        rd(ADDR_ZPOS_HIGH, 14'h0000);
        rd(ADDR_CFG1, 14'h0001);
        // burned array reloads, repair pointer 3 sets bit 3 of slot 0
        burned = 1'b1;
        image = 40'h0300020010;
        arst_n_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        rd(ADDR_ZPOS_HIGH, 14'h0018);
        rd(ADDR_CFG1, 14'h0002);
        rd(ADDR_RED, 14'h0003);
        chk({31'h0, noise}, 32'h1);
        prog = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        prog = 1'b0;
        chk({31'h0, burn}, 32'h0);
        complete_run();
    end
endmodule : tb
